/* lul_cfg.svh */
/*
  Offsets, field positions, reset values and address-bit positions of the load unit.
  Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef LUL_CFG_SVH
`define LUL_CFG_SVH

`define LUL_CTRL_OFS 4'h0
`define LUL_STAT_OFS 4'h4

`define LUL_CTRL_RST 5'h00
`define LUL_CTRL_EVA_BIT 0
`define LUL_CTRL_CP0_BIT 1
`define LUL_CTRL_FPU_BIT 2
`define LUL_CTRL_REV_BIT 3
`define LUL_CTRL_BIG_BIT 4
`define LUL_CTRL_USED_MSB 4

`define LUL_STAT_LINK_BIT 0
`define LUL_STAT_BUSY_BIT 1
`define LUL_STAT_EXC_LSB 4
`define LUL_STAT_EXC_MSB 7

`define LUL_LANE_BIT 1
`define LUL_DWORD_LANE_BIT 2
`define LUL_USER_OFS_MSB 8

`endif

/* lul_pkg.sv */
/*
  Types of the load unit: operations, exception causes, segment access modes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lul_pkg;

  typedef enum logic [2:0] {
    op_user_space_halfword_unsigned_load,
    op_linked_word_load,
    op_user_space_linked_word_load,
    op_upper_immediate_load,
    op_indexed_unaligned_fp_doubleword_load,
    op_plain_word_load
  } lul_op_e;

  typedef enum logic [3:0] {
    exc_none,
    exc_reserved_instruction,
    exc_coprocessor_unusable,
    exc_address_error,
    exc_tlb_refill,
    exc_tlb_invalid,
    exc_watch
  } lul_exc_e;

  typedef enum logic [2:0] {
    seg_unmapped_kernel,
    seg_mapped_kernel,
    seg_mapped_supervisor,
    seg_unmapped_user_access_mode,
    seg_mapped_user_supervisor_kernel_mode,
    seg_mapped_user_unmapped_kernel_mode
  } lul_seg_e;

  typedef enum logic [1:0] {
    st_idle,
    st_read_lo,
    st_read_hi
  } lul_state_e;

endpackage

/* lul_load_unit.sv */
/*
  Load execution unit: address forming, alignment and exception selection, data
  extraction and the link flag of the atomic sequence.
  Assumes a combined translation and memory port that answers each held request
  with one ack cycle, and a plain register port clocked by clock_in.
*/
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "lul_cfg.svh"

// Function
// - User-space-from-kernel loads exist only when enhanced addressing is present.
// - User halfword load needs system-coprocessor access and a user-accessible segment mode.
// - Halfword load with effective address bit zero set raises address error.
// - Linked load adds sign-extended offset to base, returns the aligned word.
// - Each linked load sets the link flag, replacing any earlier sequence.
// - A later conditional store ends the active sequence.
// - Linked loads elsewhere never by themselves clear this link flag.
// - An abandoned sequence needs no store and causes no error.
// - Both linked forms raise address error when low two bits are nonzero.
// - User linked load matches ordinary one but uses user-mode mapping.
// - User linked load may raise refill, invalid, address, reserved, watch, unusable.
// - Ordinary linked load raises only refill, invalid, address error and watch.
// - Upper immediate load returns immediate above sixteen zeros, never faults.
// - Indexed unaligned load sums base and index, clears low three bits.
// - Indexed load joins two word reads, second with address bit two inverted.
// - Indexed unaligned load raises unusable, refill, invalid, watch only.
// - Plain word load returns aligned word, zero-extended to register width.
// - Plain word load raises address error when low two bits are nonzero.
// - User halfword load zero-extends the halfword, nine-bit signed offset.
module lul_load_unit
  import lul_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  // Instruction issue
  input wire logic issue_valid_in,
  input wire lul_op_e issue_op_in,
  input wire logic [31:0] base_in,
  input wire logic [31:0] index_in,
  input wire logic [15:0] offset_in,
  input wire logic [4:0] dest_in,
  output logic issue_ready_out,
  // Translation and memory
  output logic mem_req_out,
  output logic [31:0] mem_addr_out,
  output logic mem_user_map_out,
  input wire logic mem_ack_in,
  input wire logic [31:0] mem_data_in,
  input wire logic mem_tlb_refill_in,
  input wire logic mem_tlb_invalid_in,
  input wire logic mem_watch_in,
  input wire lul_seg_e mem_seg_mode_in,
  // Conditional store completion
  input wire logic cond_store_done_in,
  // Writeback and exceptions
  output logic wb_valid_out,
  output logic wb_fp_out,
  output logic [4:0] wb_dest_out,
  output logic [63:0] wb_data_out,
  output logic exc_valid_out,
  output lul_exc_e exc_code_out,
  output logic link_flag_out
);

  lul_state_e state;
  lul_op_e op_q;
  logic [31:0] ea_q;
  logic [4:0] dest_q;
  logic [31:0] lo_q;
  logic [`LUL_CTRL_USED_MSB:0] ctrl;
  lul_exc_e last_exc;

  // Control fields
  wire eva_present = ctrl[`LUL_CTRL_EVA_BIT];
  wire cp0_enable = ctrl[`LUL_CTRL_CP0_BIT];
  wire fpu_enable = ctrl[`LUL_CTRL_FPU_BIT];
  wire rev_endian = ctrl[`LUL_CTRL_REV_BIT];
  wire big_endian = ctrl[`LUL_CTRL_BIG_BIT];
  wire swap_lane = big_endian ^ rev_endian;

  // Issue decode
  wire is_uhalf = issue_op_in == op_user_space_halfword_unsigned_load;
  wire is_link = issue_op_in == op_linked_word_load;
  wire is_ulink = issue_op_in == op_user_space_linked_word_load;
  wire is_upper = issue_op_in == op_upper_immediate_load;
  wire is_fpdw = issue_op_in == op_indexed_unaligned_fp_doubleword_load;
  wire is_word = issue_op_in == op_plain_word_load;
  wire is_user = is_uhalf | is_ulink;
  wire take = issue_valid_in & (state == st_idle);

  // Effective addresses
  wire [31:0] ofs16 = {{16{offset_in[15]}}, offset_in};
  wire [31:0] ofs9 = {{23{offset_in[`LUL_USER_OFS_MSB]}}, offset_in[`LUL_USER_OFS_MSB:0]};
  wire [31:0] ea_disp = base_in + (is_uhalf ? ofs9 : ofs16);
  wire carry3 = ({1'b0, base_in[2:0]} + {1'b0, index_in[2:0]}) > 4'h7;
  wire [31:0] ea_idx = {base_in[31:3] + index_in[31:3] + {28'h0000000, carry3}, 3'b000};
  wire [31:0] ea = is_fpdw ? ea_idx : ea_disp;
  wire [31:0] addr_lo = {ea[31:3], swap_lane, 2'b00};

  // Issue-time exceptions
  wire ri_err = is_user & ~eva_present;
  wire cpu_err = (is_user & ~cp0_enable) | (is_fpdw & ~fpu_enable);
  wire half_misal = is_uhalf & ea[0];
  wire link_misal = (is_link | is_ulink) & (ea[1:0] != 2'b00);
  wire word_misal = is_word & (ea[1:0] != 2'b00);
  wire align_err = half_misal | link_misal | word_misal;
  wire lul_exc_e issue_exc = ri_err ? exc_reserved_instruction :
                             cpu_err ? exc_coprocessor_unusable :
                             align_err ? exc_address_error : exc_none;

  // Response-time exceptions; no alignment check ever reaches the indexed load
  wire seg_user_ok = (mem_seg_mode_in == seg_unmapped_user_access_mode) |
                     (mem_seg_mode_in == seg_mapped_user_supervisor_kernel_mode) |
                     (mem_seg_mode_in == seg_mapped_user_unmapped_kernel_mode);
  wire q_user = (op_q == op_user_space_halfword_unsigned_load) |
                (op_q == op_user_space_linked_word_load);
  wire lul_exc_e resp_exc = mem_tlb_refill_in ? exc_tlb_refill :
                            mem_tlb_invalid_in ? exc_tlb_invalid :
                            (q_user & ~seg_user_ok) ? exc_address_error :
                            mem_watch_in ? exc_watch : exc_none;
  wire resp_ok = resp_exc == exc_none;

  // Data extraction
  wire lane = ea_q[`LUL_LANE_BIT] ^ swap_lane;
  wire [15:0] half = lane ? mem_data_in[31:16] : mem_data_in[15:0];
  wire [63:0] half_ext = {48'h000000000000, half};
  wire [63:0] word_ext = {32'h00000000, mem_data_in};
  wire [63:0] dword = {mem_data_in, lo_q};
  wire [63:0] upper_val = {32'h00000000, offset_in, 16'h0000};

  // Completion
  wire ack_lo = (state == st_read_lo) & mem_ack_in;
  wire ack_hi = (state == st_read_hi) & mem_ack_in;
  wire q_fpdw = op_q == op_indexed_unaligned_fp_doubleword_load;
  wire q_link = (op_q == op_linked_word_load) | (op_q == op_user_space_linked_word_load);
  wire go_hi = ack_lo & q_fpdw & resp_ok;
  wire done_ok = (ack_lo & ~q_fpdw & resp_ok) | (ack_hi & resp_ok);
  wire done_err = (ack_lo | ack_hi) & ~resp_ok;
  wire issue_err = take & ~is_upper & (issue_exc != exc_none);
  wire issue_mem = take & ~is_upper & (issue_exc == exc_none);
  wire issue_upper = take & is_upper;

  // Link flag; a linked load on another core has no path here, and no timer drops it
  wire link_set = ack_lo & q_link & resp_ok;
  wire next_link = link_set | (link_flag_out & ~cond_store_done_in);

  wire [63:0] next_wb_data = issue_upper ? upper_val :
                             ack_hi ? dword :
                             (op_q == op_user_space_halfword_unsigned_load) ? half_ext :
                             word_ext;
  wire next_wb_valid = issue_upper | done_ok;
  wire next_exc_valid = issue_err | done_err;
  wire lul_exc_e next_exc = issue_err ? issue_exc : resp_exc;

  // Register read decode
  wire sel_ctrl = reg_addr_in == `LUL_CTRL_OFS;
  wire sel_stat = reg_addr_in == `LUL_STAT_OFS;
  wire [31:0] stat_word = {24'h000000, last_exc, 2'b00, state != st_idle, link_flag_out};
  wire [31:0] ctrl_word = {27'h0000000, ctrl};
  wire [31:0] next_rdata = ~reg_read_in ? 32'h00000000 :
                           sel_ctrl ? ctrl_word :
                           sel_stat ? stat_word : 32'h00000000;

  // Register and capture next values
  wire [`LUL_CTRL_USED_MSB:0] next_ctrl = (reg_write_in & sel_ctrl) ?
                                          reg_wdata_in[`LUL_CTRL_USED_MSB:0] : ctrl;
  wire lul_op_e next_op = issue_mem ? issue_op_in : op_q;
  wire [31:0] next_ea = issue_mem ? ea : ea_q;
  wire [4:0] next_dest = issue_mem ? dest_in : dest_q;
  wire [31:0] next_lo = go_hi ? mem_data_in : lo_q;
  wire next_user_map = issue_mem ? is_user : mem_user_map_out;
  wire next_wb_fp = next_wb_valid & ~issue_upper & q_fpdw;
  wire [4:0] next_wb_dest = issue_upper ? dest_in : dest_q;
  wire lul_exc_e next_exc_code = next_exc_valid ? next_exc : exc_none;
  wire lul_exc_e next_last_exc = next_exc_valid ? next_exc : last_exc;
  wire next_ready = (state == st_idle) ? ~issue_mem : (done_ok | done_err);

  // Read sequencer
  lul_state_e next_state;
  logic next_mem_req;
  logic [31:0] next_mem_addr;

  always_comb begin
    next_state = state;
    next_mem_req = mem_req_out;
    next_mem_addr = mem_addr_out;
    case (state)
      st_idle: begin
        if (issue_mem) begin
          next_state = st_read_lo;
          next_mem_req = 1'b1;
          next_mem_addr = is_fpdw ? addr_lo : {ea[31:2], 2'b00};
        end
      end
      st_read_lo: begin
        if (go_hi) begin
          next_state = st_read_hi;
          next_mem_addr = {mem_addr_out[31:3], ~mem_addr_out[`LUL_DWORD_LANE_BIT],
                           2'b00};
        end else if (mem_ack_in) begin
          next_state = st_idle;
          next_mem_req = 1'b0;
        end
      end
      st_read_hi: begin
        if (mem_ack_in) begin
          next_state = st_idle;
          next_mem_req = 1'b0;
        end
      end
      default: begin
        next_state = st_idle;
        next_mem_req = 1'b0;
      end
    endcase
  end

  // One register per block keeps every reset branch constant-only
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl <= `LUL_CTRL_RST;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 32'h00000000;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op_q <= op_plain_word_load;
    end else begin
      op_q <= next_op;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ea_q <= 32'h00000000;
    end else begin
      ea_q <= next_ea;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dest_q <= 5'h00;
    end else begin
      dest_q <= next_dest;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lo_q <= 32'h00000000;
    end else begin
      lo_q <= next_lo;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_req_out <= 1'b0;
    end else begin
      mem_req_out <= next_mem_req;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_addr_out <= 32'h00000000;
    end else begin
      mem_addr_out <= next_mem_addr;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_user_map_out <= 1'b0;
    end else begin
      mem_user_map_out <= next_user_map;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wb_valid_out <= 1'b0;
    end else begin
      wb_valid_out <= next_wb_valid;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wb_fp_out <= 1'b0;
    end else begin
      wb_fp_out <= next_wb_fp;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wb_dest_out <= 5'h00;
    end else begin
      wb_dest_out <= next_wb_dest;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wb_data_out <= 64'h0000000000000000;
    end else begin
      wb_data_out <= next_wb_data;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      exc_valid_out <= 1'b0;
    end else begin
      exc_valid_out <= next_exc_valid;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      exc_code_out <= exc_none;
    end else begin
      exc_code_out <= next_exc_code;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      last_exc <= exc_none;
    end else begin
      last_exc <= next_last_exc;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      link_flag_out <= 1'b0;
    end else begin
      link_flag_out <= next_link;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      issue_ready_out <= 1'b0;
    end else begin
      issue_ready_out <= next_ready;
    end
  end

endmodule

/* lul_load_unit_monitor.sv */
/*
  Port checker of the load unit.
  Assumes binding to lul_load_unit, whose ports it copies by name.
*/
`timescale 1ns/1ps
module lul_load_unit_monitor
  import lul_pkg::*;
(
  // Watched ports
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic issue_valid_in,
  input wire lul_op_e issue_op_in,
  input wire logic [31:0] base_in,
  input wire logic [15:0] offset_in,
  input wire logic issue_ready_out,
  input wire logic mem_req_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic [31:0] mem_data_in,
  input wire logic mem_tlb_refill_in,
  input wire logic mem_tlb_invalid_in,
  input wire logic mem_watch_in,
  input wire logic cond_store_done_in,
  input wire logic wb_valid_out,
  input wire logic [63:0] wb_data_out,
  input wire logic exc_valid_out,
  input wire lul_exc_e exc_code_out,
  input wire logic link_flag_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  lul_op_e op_q;
  logic acked;
  wire take = issue_valid_in && issue_ready_out;
  wire clean = !mem_tlb_refill_in && !mem_tlb_invalid_in && !mem_watch_in;
  wire [31:0] ea = base_in + {{16{offset_in[15]}}, offset_in};
  wire fp_q = op_q == op_indexed_unaligned_fp_doubleword_load;
  // Op kept per take; a busy unit takes nothing, so it stays valid
  always_ff @(posedge clock_in or negedge resetn_in)
    if (!resetn_in) begin
      op_q <= op_upper_immediate_load;
      acked <= 1'b0;
    end else begin
      op_q <= take ? issue_op_in : op_q;
      acked <= take ? 1'b0 : (acked | mem_ack_in);
    end
  a_upper_result: assert property (take && issue_op_in == op_upper_immediate_load |=>
    wb_valid_out && !exc_valid_out && wb_data_out == {32'h0, $past(offset_in), 16'h0})
    else $error("bad upper load");
  a_word_align: assert property (take && ea[1:0] != 2'b00 &&
    (issue_op_in == op_plain_word_load || issue_op_in == op_linked_word_load) |=>
    exc_valid_out && exc_code_out == exc_address_error && !mem_req_out)
    else $error("bad alignment");
  a_link_opens: assert property (mem_ack_in && op_q == op_linked_word_load && clean |=>
    link_flag_out && wb_valid_out && wb_data_out == {32'h0, $past(mem_data_in)})
    else $error("bad linked load");
  a_link_kept: assert property (link_flag_out && !cond_store_done_in |=> link_flag_out)
    else $error("link lost");
  a_store_ends: assert property (cond_store_done_in && !mem_ack_in |=> !link_flag_out)
    else $error("link not cleared");
  a_second_read: assert property (mem_ack_in && fp_q && !acked && clean |=>
    mem_req_out && mem_addr_out == ($past(mem_addr_out) ^ 32'h4))
    else $error("bad second read");
  a_fp_no_align: assert property (exc_valid_out && fp_q |->
    exc_code_out != exc_address_error)
    else $error("fp alignment fault");
  a_linked_causes: assert property (exc_valid_out && op_q == op_linked_word_load |->
    exc_code_out inside {exc_address_error, exc_tlb_refill, exc_tlb_invalid, exc_watch})
    else $error("bad linked cause");
endmodule

bind lul_load_unit lul_load_unit_monitor lul_load_unit_monitor_inst (.*);

/* lul_mem_model.sv */
/*
  Memory side model: one ack per held read, prompt or slow.
  Assumes req and address stay held until ack.
*/
`timescale 1ns/1ps
module lul_mem_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Read port
  input wire logic req_in,
  input wire logic [31:0] addr_in,
  input wire logic slow_in,
  output logic ack_out,
  output logic [31:0] data_out
);
  logic [1:0] wait_cnt;
  // Only synchronizable word locations exist here
  always_ff @(posedge clock_in or negedge resetn_in)
    if (!resetn_in) begin
      ack_out <= 1'b0;
      data_out <= 32'h0;
      wait_cnt <= 2'h0;
    end else if (req_in && !ack_out && (!slow_in || wait_cnt == 2'h3)) begin
      ack_out <= 1'b1;
      data_out <= {addr_in[31:2], 2'b00} ^ 32'h5a3c96e1;
      wait_cnt <= 2'h0;
    end else begin
      ack_out <= 1'b0;
      data_out <= ~data_out; // Stale data alternates with its complement
      wait_cnt <= wait_cnt + {1'b0, req_in && !ack_out};
    end
endmodule

/* testbench.sv */
/*
  Self-checking bench of the load unit with its memory model.
  Assumes lul_pkg, the design, the monitor and the model are compiled first.
*/
`timescale 1ns/1ps
`include "lul_cfg.svh"
module testbench
  import lul_pkg::*;
;
  logic clock_in = 1'b0, resetn_in = 1'b0, reg_write_in = 1'b0, reg_read_in = 1'b0;
  logic issue_valid_in = 1'b0, slow = 1'b0, cond_store_done_in = 1'b0;
  logic mem_tlb_refill_in = 1'b0, mem_tlb_invalid_in = 1'b0, mem_watch_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0, base_in = 32'h0, index_in = 32'h0, b, ea, rd;
  logic [15:0] offset_in = 16'h0, o;
  logic [4:0] dest_in = 5'h0, wb_dest_out;
  lul_op_e issue_op_in = op_plain_word_load, op;
  lul_seg_e mem_seg_mode_in = seg_mapped_user_unmapped_kernel_mode;
  logic issue_ready_out, mem_req_out, mem_user_map_out, mem_ack_in, wb_valid_out, wb_fp_out;
  logic exc_valid_out, link_flag_out;
  logic [31:0] reg_rdata_out, mem_addr_out, mem_data_in;
  logic [63:0] wb_data_out;
  lul_exc_e exc_code_out;
  logic [75:0] got;
  int fail_count = 0, tests_run = 0;
  lul_op_e pick[4] = '{op_plain_word_load, op_linked_word_load,
    op_user_space_linked_word_load, op_upper_immediate_load};
  always #2.5 clock_in = ~clock_in;
  lul_load_unit lul_load_unit_inst (.*);
  lul_mem_model lul_mem_model_inst (.clock_in, .resetn_in, .req_in(mem_req_out),
    .addr_in(mem_addr_out), .slow_in(slow), .ack_out(mem_ack_in), .data_out(mem_data_in));
  function automatic logic [31:0] word_at(logic [31:0] a);
    return {a[31:2], 2'b00} ^ 32'h5a3c96e1;
  endfunction
  function automatic logic [75:0] ok(logic fp, logic [63:0] d);
    return {1'b0, exc_none, 1'b1, fp, dest_in, d};
  endfunction
  function automatic logic [75:0] err(lul_exc_e c);
    return {1'b1, c, 71'h0};
  endfunction
  task automatic chk(logic [75:0] seen, logic [75:0] want);
    tests_run++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic reg_wr(logic [3:0] a, logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic reg_rd(logic [3:0] a);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    @(negedge clock_in);
    rd = reg_rdata_out;
    @(posedge clock_in);
  endtask
  task automatic run(lul_op_e p, logic [31:0] bb, logic [31:0] x, logic [15:0] oo);
    int n;
    issue_op_in <= p;
    base_in <= bb;
    index_in <= x;
    offset_in <= oo;
    dest_in <= 5'($urandom);
    slow <= 1'($urandom);
    issue_valid_in <= 1'b1;
    @(posedge clock_in);
    issue_valid_in <= 1'b0;
    @(negedge clock_in);
    for (n = 0; n < 40 && wb_valid_out !== 1'b1 && exc_valid_out !== 1'b1; n++)
      @(negedge clock_in);
    if (n == 40) begin
      fail_count++;
      results();
    end
    got = (exc_valid_out === 1'b1) ? {1'b1, exc_code_out, 71'h0} :
      {1'b0, exc_code_out, wb_valid_out, wb_fp_out, wb_dest_out, wb_data_out};
    @(posedge clock_in);
  endtask
  initial begin
    rd = $urandom(46524);
    repeat (12) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    reg_rd(4'h8);
    chk(76'(rd), 76'h0);
    reg_wr(`LUL_CTRL_OFS, 32'h7);
    reg_rd(`LUL_CTRL_OFS);
    chk(76'(rd), 76'h7);
    for (int i = 0; i < 40; i++) begin
      op = pick[$urandom_range(3)];
      b = $urandom;
      o = 16'($urandom);
      ea = b + {{16{o[15]}}, o};
      if ($urandom_range(1)) b = b - {30'h0, ea[1:0]};
      ea = b + {{16{o[15]}}, o};
      run(op, b, $urandom, o);
      if (op == op_upper_immediate_load) chk(got, ok(1'b0, {32'h0, o, 16'h0}));
      else if (ea[1:0] != 2'b00) chk(got, err(exc_address_error));
      else chk(got, ok(1'b0, {32'h0, word_at(ea)}));
    end
    for (int k = 0; k < 8; k++) begin
      reg_wr(`LUL_CTRL_OFS, {27'h0, k[2:1], 3'h7});
      o = 16'($urandom) & 16'hfffe;
      b = $urandom & 32'hfffffffe;
      ea = b + {{23{o[8]}}, o[8:0]};
      rd = word_at(ea);
      run(op_user_space_halfword_unsigned_load, b, 32'h0, o);
      chk(got, ok(1'b0, {48'h0, (ea[1] ^ k[1] ^ k[2]) ? rd[31:16] : rd[15:0]}));
      b = $urandom;
      ea = $urandom;
      rd = ((b + ea) & 32'hfffffff8) ^ {29'h0, k[1] ^ k[2], 2'b00};
      run(op_indexed_unaligned_fp_doubleword_load, b, ea, 16'h0);
      chk(got, ok(1'b1, {word_at(rd ^ 32'h4), word_at(rd)}));
    end
    run(op_user_space_halfword_unsigned_load, 32'h1001, 32'h0, 16'h0);
    chk(got, err(exc_address_error));
    mem_seg_mode_in <= seg_mapped_kernel;
    run(op_user_space_halfword_unsigned_load, 32'h1000, 32'h0, 16'h0);
    chk(got, err(exc_address_error));
    for (int m = 3; m < 6; m++) begin
      mem_seg_mode_in <= lul_seg_e'(m);
      run(op_user_space_linked_word_load, 32'h3000, 32'h0, 16'h4);
      chk(got, ok(1'b0, {32'h0, word_at(32'h3004)}));
      chk(76'(mem_user_map_out), 76'h1);
    end
    reg_wr(`LUL_CTRL_OFS, 32'h1);
    run(op_user_space_halfword_unsigned_load, 32'h1000, 32'h0, 16'h0);
    chk(got, err(exc_coprocessor_unusable));
    reg_wr(`LUL_CTRL_OFS, 32'h0);
    run(op_user_space_linked_word_load, 32'h3000, 32'h0, 16'h0);
    chk(got, err(exc_reserved_instruction));
    run(op_indexed_unaligned_fp_doubleword_load, 32'h3003, 32'h1, 16'h0);
    chk(got, err(exc_coprocessor_unusable));
    chk(76'(link_flag_out), 76'h1);
    cond_store_done_in <= 1'b1;
    @(posedge clock_in);
    cond_store_done_in <= 1'b0;
    @(negedge clock_in);
    chk(76'(link_flag_out), 76'h0);
    @(posedge clock_in);
    for (int f = 0; f < 3; f++) begin
      {mem_tlb_refill_in, mem_tlb_invalid_in, mem_watch_in} <= 3'(3'b100 >> f);
      run(op_linked_word_load, 32'h40, 32'h0, 16'h0);
      chk(got, err(f == 0 ? exc_tlb_refill : f == 1 ? exc_tlb_invalid : exc_watch));
    end
    chk(76'(mem_user_map_out), 76'h0);
    reg_rd(`LUL_STAT_OFS);
    chk(76'(rd), {68'h0, exc_watch, 4'h0});
    results();
  end
endmodule
